// file: core/cscp_control_port.sv
`timescale 1ns/1ps
`default_nettype none
module cscp_control_port
  import cscp_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic       clk_sys_i,            // System clock
  input  wire logic       rst_i,                // Sync reset
  input  wire logic       bit_clock_in_i,       // Serial bit clock
  input  wire logic       frame_pulse_n_i,      // Slot frame, active low
  input  wire logic       ca_neg_i,             // Select at negative level
  input  wire logic       ca_pos_i,             // Select at positive level
  input  wire logic       control_serial_in_i,  // Control serial input
  input  wire logic       pcm_serial_in_i,      // PCM serial input
  input  wire logic [7:0] encoder_word_i,       // Word from encoder
  output logic            pcm_serial_out_o,     // PCM serial output
  output logic            pcm_serial_out_oe_o,  // PCM output driven
  output logic [7:0]      decoder_word_o,       // Word to decoder
  output logic [5:0]      uncommitted_outputs_o,// Control outputs
  output cscp_glc_s       gain_loop_control_o,  // Gain and loop register
  output cscp_otc_s       output_test_control_o,// Output and test register
  output logic            powerdown_o,          // Analog sections off
  output logic            analog_out_ground_o,  // Output buffer input grounded
  output logic            tx_from_rx_o,         // Transmit filter fed by receive
  output logic [1:0]      test_sel_o,           // Active test mode
  output logic            init_busy_o           // Power-up hold active
);

  logic       bc_prev_reg, bc_prev_next;
  logic       armed_reg, armed_next;
  logic       slot_reg, slot_next;
  logic       done_reg, done_next;
  logic [2:0] bitcnt_reg, bitcnt_next;
  cscp_ca_e   ca_reg, ca_next;
  cscp_glc_s  glc_reg, glc_next;
  cscp_otc_s  otc_reg, otc_next;
  cscp_mode_e mode_reg, mode_next;
  logic [7:0] pcm_rx_reg, pcm_rx_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic       oe_reg, oe_next;
  logic [4:0] init_reg, init_next;
  logic       cst_prev_reg, cst_prev_next;
  logic       stable_reg, stable_next;

  logic       bc_rise, bc_fall, shift_en, init_done;
  logic       dig_loop;
  logic [7:0] cst_word, pcm_word;
  cscp_ca_e   ca_now;
  logic [5:0] sd_mask;

  assign bc_rise   = bit_clock_in_i & ~bc_prev_reg;
  assign bc_fall   = ~bit_clock_in_i & bc_prev_reg;
  assign shift_en  = slot_reg & bc_fall;
  assign init_done = (init_reg == INIT_EDGES);
  assign dig_loop  = (mode_reg == MODE_SERIAL) && (glc_reg.func == FUNC_DIGLOOP);
  assign sd_mask   = FULL_VARIANT ? SD_MASK_FULL : SD_MASK_LITE;

  always_comb begin
    ca_now = CA_GND;
    if (ca_neg_i) begin
      ca_now = CA_NEG;
    end else if (ca_pos_i) begin
      ca_now = CA_POS;
    end
  end

  cscp_shift_in #(.W(WORD_BITS)) u_cst_rx (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .shift_i   (shift_en),
    .bit_i     (control_serial_in_i),
    .word_o    (cst_word)
  );

  cscp_shift_in #(.W(WORD_BITS)) u_pcm_rx (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .shift_i   (shift_en),
    .bit_i     (pcm_serial_in_i),
    .word_o    (pcm_word)
  );

  // Slot timing: opens on the first rise with frame low
  always_comb begin
    bc_prev_next = bit_clock_in_i;
    armed_next   = armed_reg;
    slot_next    = slot_reg;
    done_next    = 1'b0;
    bitcnt_next  = bitcnt_reg;
    ca_next      = ca_reg;
    tx_sh_next   = tx_sh_reg;
    oe_next      = oe_reg;
    init_next    = init_reg;
    if (bc_rise && !init_done) begin
      init_next = init_reg + 5'h01;
    end
    if (bc_rise && frame_pulse_n_i) begin
      armed_next = 1'b1;
    end
    if (bc_rise && !slot_reg && armed_reg && !frame_pulse_n_i && init_done) begin
      slot_next   = 1'b1;
      armed_next  = 1'b0;
      bitcnt_next = 3'h0;
      ca_next     = ca_now;
      tx_sh_next  = dig_loop ? pcm_rx_reg : encoder_word_i;
      oe_next     = (ca_now != CA_POS) && !powerdown_o;
    end else if (bc_rise && slot_reg && bitcnt_reg != 3'h0) begin
      tx_sh_next = {tx_sh_reg[6:0], 1'b0};
    end
    if (shift_en) begin
      bitcnt_next = bitcnt_reg + 3'h1;
      if (bitcnt_reg == LAST_BIT) begin
        slot_next = 1'b0;
        oe_next   = 1'b0;
        done_next = 1'b1;
      end
    end
    if (powerdown_o) begin
      oe_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bc_prev_reg <= 1'b0;
      armed_reg   <= 1'b0;
      slot_reg    <= 1'b0;
      done_reg    <= 1'b0;
      bitcnt_reg  <= 3'h0;
      ca_reg      <= CA_GND;
      tx_sh_reg   <= 8'h00;
      oe_reg      <= 1'b0;
      init_reg    <= 5'h00;
    end else begin
      bc_prev_reg <= bc_prev_next;
      armed_reg   <= armed_next;
      slot_reg    <= slot_next;
      done_reg    <= done_next;
      bitcnt_reg  <= bitcnt_next;
      ca_reg      <= ca_next;
      tx_sh_reg   <= tx_sh_next;
      oe_reg      <= oe_next;
      init_reg    <= init_next;
    end
  end

  // Register commit one cycle after the eighth bit
  always_comb begin
    glc_next      = glc_reg;
    otc_next      = otc_reg;
    mode_next     = mode_reg;
    pcm_rx_next   = pcm_rx_reg;
    cst_prev_next = control_serial_in_i;
    stable_next   = stable_reg && (control_serial_in_i == cst_prev_reg);
    if (!init_done) begin
      glc_next  = GLC_RESET;
      otc_next  = OTC_RESET;
      mode_next = MODE_SERIAL;
    end else if (done_reg) begin
      stable_next = 1'b1;
      if (ca_reg != CA_POS) begin
        pcm_rx_next = pcm_word;
      end
      case (ca_reg)
        CA_NEG: begin
          if (stable_reg && cst_word == WORD_ZERO) begin
            mode_next = MODE_STATIC_NORMAL;
            glc_next  = GLC_RESET & 8'h00;
          end else if (stable_reg && cst_word == WORD_ONES) begin
            mode_next = MODE_STATIC_PD;
          end else begin
            mode_next = MODE_SERIAL;
            glc_next  = cst_word;
            otc_next  = OTC_RESET;
          end
        end
        CA_GND: begin
          mode_next = MODE_SERIAL;
          glc_next  = cst_word;
        end
        CA_POS: begin
          otc_next = cst_word;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      glc_reg      <= GLC_RESET;
      otc_reg      <= OTC_RESET;
      mode_reg     <= MODE_SERIAL;
      pcm_rx_reg   <= 8'h00;
      cst_prev_reg <= 1'b0;
      stable_reg   <= 1'b0;
    end else begin
      glc_reg      <= glc_next;
      otc_reg      <= otc_next;
      mode_reg     <= mode_next;
      pcm_rx_reg   <= pcm_rx_next;
      cst_prev_reg <= cst_prev_next;
      stable_reg   <= stable_next;
    end
  end

  // Effects of the two registers and the static modes
  always_comb begin
    powerdown_o = (mode_reg == MODE_STATIC_PD) || (glc_reg.func == FUNC_PDOWN);
    tx_from_rx_o = !powerdown_o && (mode_reg == MODE_SERIAL)
                   && (glc_reg.func == FUNC_ANALOOP);
    analog_out_ground_o = powerdown_o || tx_from_rx_o;
    test_sel_o = (mode_reg == MODE_STATIC_NORMAL) ? TEST_NONE : otc_reg.test;
    uncommitted_outputs_o = ((mode_reg == MODE_STATIC_NORMAL) ? SD_MASK_FULL
                            : otc_reg.sd) & sd_mask;
  end

  assign decoder_word_o        = dig_loop ? WORD_ZERO : pcm_rx_reg;
  assign pcm_serial_out_o      = tx_sh_reg[7];
  assign pcm_serial_out_oe_o   = oe_reg;
  assign gain_loop_control_o   = glc_reg;
  assign output_test_control_o = otc_reg;
  assign init_busy_o           = !init_done;

  pd_hiz_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    powerdown_o |=> !pcm_serial_out_oe_o) else $error("PCM output driven in powerdown");

  init_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !init_done |=> (glc_reg == GLC_RESET) && (otc_reg == OTC_RESET))
    else $error("Register changed during power-up hold");

  pos_inhibit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (slot_reg && ca_reg == CA_POS) |-> !pcm_serial_out_oe_o)
    else $error("PCM output driven with positive select");

  neg_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_reg && init_done && ca_reg == CA_NEG && cst_word != WORD_ZERO
     && cst_word != WORD_ONES) |=> (otc_reg == OTC_RESET) && (glc_reg == $past(cst_word)))
    else $error("Negative-select word not handled");

  gnd_keep_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_reg && init_done && ca_reg == CA_GND) |=> $stable(otc_reg)
     && (glc_reg == $past(cst_word))) else $error("Ground-select word not handled");

  pos_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_reg && init_done && ca_reg == CA_POS) |=> $stable(glc_reg)
     && (otc_reg == $past(cst_word))) else $error("Positive-select word not handled");

  dig_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    dig_loop |-> decoder_word_o == WORD_ZERO) else $error("Decoder not zero in loopback");

  sd_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_reg != MODE_STATIC_NORMAL) |-> uncommitted_outputs_o == (otc_reg.sd & sd_mask))
    else $error("Uncommitted outputs differ from register");

  static_notest_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_reg == MODE_STATIC_NORMAL) |-> (test_sel_o == TEST_NONE)
     && (uncommitted_outputs_o == sd_mask)) else $error("Static normal mode wrong");

  slot_bits_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (shift_en && bitcnt_reg == LAST_BIT) |=> !slot_reg ##1 done_reg == 1'b0)
    else $error("Slot did not close after eight bits");

endmodule // cscp_control_port
`default_nettype wire

// file: core/cscp_pkg.sv
package cscp_pkg;

  localparam int unsigned WORD_BITS   = 8;
  localparam int unsigned SD_COUNT    = 6;

  // Bit clock rising edges spent in power-up powerdown
  localparam logic [4:0] INIT_EDGES   = 5'h19;

  // Register reset values: powerdown forced, everything else clear
  localparam logic [7:0] GLC_RESET    = 8'hC0;
  localparam logic [7:0] OTC_RESET    = 8'h00;

  // Function field of gain_loop_control (bits 7..6)
  localparam logic [1:0] FUNC_NORMAL  = 2'h0;
  localparam logic [1:0] FUNC_DIGLOOP = 2'h1;
  localparam logic [1:0] FUNC_ANALOOP = 2'h2;
  localparam logic [1:0] FUNC_PDOWN   = 2'h3;

  // Test field of output_test_control (bits 7..6)
  localparam logic [1:0] TEST_NONE    = 2'h0;
  localparam logic [1:0] TEST_TXFILT  = 2'h1;
  localparam logic [1:0] TEST_RXFILT  = 2'h2;
  localparam logic [1:0] TEST_CODEC   = 2'h3;

  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [5:0] SD_MASK_FULL = 6'h3F;
  localparam logic [5:0] SD_MASK_LITE = 6'h0F;
  localparam logic [7:0] WORD_ZERO    = 8'h00;
  localparam logic [7:0] WORD_ONES    = 8'hFF;

  typedef struct packed {
    logic [1:0] func;
    logic [2:0] rx_gain;
    logic [2:0] tx_gain;
  } cscp_glc_s;

  typedef struct packed {
    logic [1:0] test;
    logic [5:0] sd;
  } cscp_otc_s;

  typedef enum logic [1:0] {CA_NEG, CA_GND, CA_POS} cscp_ca_e;

  typedef enum logic [1:0] {MODE_SERIAL, MODE_STATIC_NORMAL, MODE_STATIC_PD} cscp_mode_e;

endpackage

// file: core/cscp_shift_in.sv
`timescale 1ns/1ps
`default_nettype none
module cscp_shift_in #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys_i,  // System clock
  input  wire logic         rst_i,      // Sync reset
  input  wire logic         shift_i,    // Take one bit
  input  wire logic         bit_i,      // Serial data
  output logic [W-1:0]      word_o      // Word, first bit ends in MSB
);

  logic [W-1:0] word_reg;
  logic [W-1:0] word_next;

  always_comb begin
    word_next = word_reg;
    if (shift_i) begin
      word_next = {word_reg[W-2:0], bit_i};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign word_o = word_reg;

endmodule // cscp_shift_in
`default_nettype wire

// file: tb/codec_serial_control_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module codec_serial_control_port_bench;
  import cscp_pkg::*;
  logic       clk_sys_i, rst_i, bclk, frame_n, ca_neg, ca_pos, ctl, pcm_in;
  logic       pcm_out, pcm_oe, pd, agnd, txrx, busy, oe_seen;
  logic [7:0] enc_word, dec_word, rx;
  logic [5:0] sd_out;
  logic [1:0] tsel;
  cscp_glc_s  glc;
  cscp_otc_s  otc;
  int         fails = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  logic [7:0] tw [4] = '{8'h15, 8'h6A, 8'h80, 8'hFF};

  cscp_control_port #(.FULL_VARIANT(1'b1)) cscp_control_port_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bit_clock_in_i(bclk),
    .frame_pulse_n_i(frame_n), .ca_neg_i(ca_neg), .ca_pos_i(ca_pos),
    .control_serial_in_i(ctl), .pcm_serial_in_i(pcm_in), .encoder_word_i(enc_word),
    .pcm_serial_out_o(pcm_out), .pcm_serial_out_oe_o(pcm_oe), .decoder_word_o(dec_word),
    .uncommitted_outputs_o(sd_out), .gain_loop_control_o(glc),
    .output_test_control_o(otc), .powerdown_o(pd), .analog_out_ground_o(agnd),
    .tx_from_rx_o(txrx), .test_sel_o(tsel), .init_busy_o(busy));

  cscp_ctrl_model cscp_ctrl_model_inst (
    .clk_sys_i(clk_sys_i), .pcm_out_i(pcm_out), .pcm_oe_i(pcm_oe), .bclk_o(bclk),
    .frame_n_o(frame_n), .ca_neg_o(ca_neg), .ca_pos_o(ca_pos), .ctl_o(ctl),
    .pcm_o(pcm_in));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sl(input logic n, input logic p, input logic h, input logic [7:0] c,
                    input logic [7:0] w);
    cscp_ctrl_model_inst.slot(n, p, h, c, w, rx, oe_seen);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    rst_i = 1'b1;
    enc_word = 8'h5A;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(glc, GLC_RESET);
    chk(otc, OTC_RESET);
    chk({7'h0, pd}, 8'h01);
    rst_i = 1'b0;
    sl(1'b0, 1'b0, 1'b0, 8'h12, 8'h00);
    chk(glc, GLC_RESET);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys_i);
    chk({7'h0, busy}, 8'h00);
    done("init");
    // Still powered down from reset when this slot opens
    sl(1'b0, 1'b0, 1'b0, 8'hA5, 8'h3C);
    chk({7'h0, oe_seen}, 8'h00);
    chk(glc, 8'hA5);
    chk({5'h0, glc.tx_gain}, 8'h05);
    chk({5'h0, glc.rx_gain}, 8'h04);
    chk({6'h0, txrx, agnd}, 8'h03);
    chk(dec_word, 8'h3C);
    done("ground select");
    foreach (tw[i]) begin
      sl(1'b0, 1'b1, 1'b0, tw[i], 8'hE1);
      chk({6'h0, tsel}, {6'h0, tw[i][7:6]});
      chk({2'h0, sd_out}, {2'h0, tw[i][5:0]});
      chk({7'h0, oe_seen}, 8'h00);
      chk(glc, 8'hA5);
    end
    chk(dec_word, 8'h3C);
    done("positive select");
    sl(1'b1, 1'b0, 1'b0, 8'h03, 8'h22);
    chk(rx, 8'h5A);
    chk({7'h0, oe_seen}, 8'h01);
    chk(glc, 8'h03);
    chk(otc, 8'h00);
    chk({2'h0, sd_out}, 8'h00);
    chk({6'h0, tsel}, 8'h00);
    done("negative select word");
    sl(1'b0, 1'b0, 1'b0, 8'h40, 8'h96);
    sl(1'b0, 1'b0, 1'b0, 8'h40, 8'h11);
    chk(rx, 8'h96);
    chk(dec_word, 8'h00);
    done("digital loopback");
    sl(1'b0, 1'b1, 1'b0, 8'hC0, 8'h00);
    sl(1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
    // Test field set again so static normal must block it
    sl(1'b0, 1'b1, 1'b1, 8'hC0, 8'h00);
    sl(1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
    chk({2'h0, sd_out}, 8'h3F);
    chk({6'h0, tsel}, 8'h00);
    chk(glc, 8'h00);
    chk(otc, 8'hC0);
    done("static normal");
    sl(1'b1, 1'b0, 1'b1, 8'hFF, 8'h00);
    sl(1'b1, 1'b0, 1'b1, 8'hFF, 8'h00);
    chk({6'h0, pd, agnd}, 8'h03);
    chk({7'h0, oe_seen}, 8'h00);
    done("static powerdown");
    finish_test();
  end
endmodule // codec_serial_control_port_bench
`default_nettype wire

// file: tb/cscp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module cscp_ctrl_model (
  input  wire logic clk_sys_i,  // System clock
  input  wire logic pcm_out_i,  // PCM from device
  input  wire logic pcm_oe_i,   // PCM output driven
  output logic      bclk_o,     // Bit clock
  output logic      frame_n_o,  // Frame pulse, active low
  output logic      ca_neg_o,   // Select negative
  output logic      ca_pos_o,   // Select positive
  output logic      ctl_o,      // Control serial data
  output logic      pcm_o       // PCM serial data
);
  logic [1:0] div_reg = 2'h0;
  initial begin
    bclk_o = 1'b0;
    frame_n_o = 1'b1;
    ca_neg_o = 1'b0;
    ca_pos_o = 1'b0;
    ctl_o = 1'b0;
    pcm_o = 1'b0;
  end
  // Free-running bit clock, three system cycles per phase
  always @(negedge clk_sys_i) begin
    if (div_reg == 2'h2) begin
      div_reg <= 2'h0;
      bclk_o <= ~bclk_o;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  // One 8-bit slot; hold keeps the control line static afterwards
  task automatic slot(input logic neg, input logic pos, input logic hold,
                      input logic [7:0] cw, input logic [7:0] pw,
                      output logic [7:0] rx, output logic seen_oe);
    seen_oe = 1'b0;
    @(negedge bclk_o);
    frame_n_o = 1'b0;
    ca_neg_o = neg;
    ca_pos_o = pos;
    for (int i = 7; i >= 0; i--) begin
      @(posedge bclk_o);
      ctl_o = cw[i];
      pcm_o = pw[i];
      @(negedge bclk_o);
      // Released line reads as the inverse of its last level
      rx[i] = pcm_oe_i ? pcm_out_i : ~pcm_out_i;
      seen_oe = seen_oe | pcm_oe_i;
    end
    frame_n_o = 1'b1;
    // Last bit held to the next rise; device samples after the fall
    @(posedge bclk_o);
    pcm_o = ~pw[0];
    if (!hold) begin
      ctl_o = ~cw[0];
    end
    repeat (2) @(posedge bclk_o);
  endtask
endmodule // cscp_ctrl_model
`default_nettype wire
